// ---- shared/tape_status_defines.svh ----
`ifndef TAPE_STATUS_DEFINES_SVH
`define TAPE_STATUS_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_DATA_LO 8'h08
`define OFS_DATA_HI 8'h0C
`define OFS_WORDS 8'h10
`define OFS_IRQ_STAT 8'h14
`define OFS_IRQ_EN 8'h18
`define OFS_IRQ_CLR 8'h1C

// ----------------------------------------
// status word fields
// ----------------------------------------
`define ST_EOF 0
`define ST_PERR 1
`define ST_AFC 2
`define ST_LATE 3
`define ST_LP 4
`define ST_ILOCK 5
`define ST_BUSY 6
`define ST_EOTW 7
`define ST_INVAL 8
`define ST_FCM_LSB 9
`define ST_FCM_MSB 12
`define ST_DONE 13
`define ST_W 14
`define ST_RESET 14'h0000

// ----------------------------------------
// interrupt bits
// ----------------------------------------
`define IRQ_DONE 0
`define IRQ_WORD 1
`define IRQ_LATE 2
`define IRQ_W 3
`define IRQ_RESET 3'h0

// ----------------------------------------
// frame and block constants
// ----------------------------------------
`define EOF_PATTERN 9'h013
`define FRAMES_PER_WORD 4
`define MOD_FRAMES 4'hE
`define NOISE_FRAMES 10

`endif

// ---- shared/tape_status_pkg.sv ----
package tape_status_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_READ = 2'b01,
		ST_DRAIN = 2'b10,
		ST_REWIND = 2'b11
	} state_t;

	typedef enum logic [2:0] {
		FN_NONE = 3'b000,
		FN_RD_FWD = 3'b001,
		FN_RD_BWD = 3'b010,
		FN_BOOT = 3'b011,
		FN_REWIND = 3'b100
	} func_t;

endpackage : tape_status_pkg

// ---- logic/frame_packer.sv ----
`timescale 1ns/1ps
`include "tape_status_defines.svh"

module frame_packer #(
	parameter int FW = 9
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// frames in
	input wire logic clr_i,
	input wire logic frame_valid_i,
	input wire logic [FW-1:0] frame_i,
	input wire logic flush_i,
	// words out
	output logic [4*FW-1:0] word_o,
	output logic word_valid_o
);

	logic [4*FW-1:0] acc_q;
	logic [1:0] idx_q;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || clr_i) begin
			acc_q <= '0;
			idx_q <= 2'h0;
			word_o <= '0;
			word_valid_o <= 1'b0;
		end else begin
			word_valid_o <= 1'b0;
			if (frame_valid_i) begin
				// first frame lands in the top slot
				acc_q[(3-idx_q)*FW +: FW] <= frame_i;
				idx_q <= idx_q + 2'h1;
				if (idx_q == 2'h3) begin
					word_o <= {acc_q[4*FW-1:FW], frame_i};
					word_valid_o <= 1'b1;
					acc_q <= '0;
				end
			end else if (flush_i && idx_q != 2'h0) begin
				// unfilled slots stay zero
				word_o <= acc_q;
				word_valid_o <= 1'b1;
				acc_q <= '0;
				idx_q <= 2'h0;
			end
		end
	end

endmodule : frame_packer

// ---- logic/noise_gate.sv ----
`timescale 1ns/1ps
`include "tape_status_defines.svh"

module noise_gate #(
	parameter int FRAME_CYCLES = 50
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// watch
	input wire logic arm_i,
	input wire logic frame_valid_i,
	output logic silence_o
);

	localparam logic [19:0] LIMIT = 20'(`NOISE_FRAMES * FRAME_CYCLES);

	logic [19:0] cnt_q;
	logic seen_q;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !arm_i) begin
			cnt_q <= 20'h0_0000;
			seen_q <= 1'b0;
			silence_o <= 1'b0;
		end else begin
			silence_o <= 1'b0;
			if (frame_valid_i) begin
				cnt_q <= 20'h0_0000;
				seen_q <= 1'b1;
			end else if (seen_q) begin
				cnt_q <= cnt_q + 20'h0_0001;
				// ten frame times of quiet after a recording
				if (cnt_q == LIMIT - 20'h0_0001) begin
					silence_o <= 1'b1;
					seen_q <= 1'b0;
				end
			end
		end
	end

endmodule : noise_gate

// ---- logic/tape_read_block_status.sv ----
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "tape_status_defines.svh"

module tape_read_block_status #(
	parameter int FRAME_CYCLES = 50
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// tape read path
	input wire logic frame_valid_i,
	input wire logic [8:0] frame_i,
	input wire logic frame_perr_i,
	input wire logic diag_frame_i,
	input wire logic lrc_err_i,
	input wire logic block_end_i,
	// tape unit condition
	input wire logic load_point_i,
	input wire logic eot_warn_i,
	input wire logic interlock_i,
	input wire logic unit_busy_i,
	input wire logic unit_9trk_i,
	// tape motion
	output logic motion_fwd_o,
	output logic motion_bwd_o,
	output logic motion_rewind_o,
	// interrupt
	output logic irq_o
);

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	logic req;
	logic commit;
	logic wr_commit;
	logic rd_commit;

	assign req = wb_cyc_i & wb_stb_i;
	// a write or read side effect lands on the edge the master sees ack
	assign commit = req & wb_ack_o;
	assign wr_commit = commit & wb_we_i;
	assign rd_commit = commit & ~wb_we_i;

	// ----------------------------------------
	// block state
	// ----------------------------------------
	tape_status_pkg::state_t st_q;
	tape_status_pkg::func_t fn_q;
	logic [`ST_W-1:0] stat_q;
	logic [15:0] frames_q;
	logic [3:0] mod_q;
	logic [8:0] first_q;
	logic perr_q;
	logic diag_q;
	logic lp_q;
	logic noise_q;
	logic late_q;
	logic [15:0] made_q;
	logic [15:0] acc_q;
	logic [35:0] hold_q;
	logic hold_v_q;
	logic [`IRQ_W-1:0] irq_st_q;
	logic [`IRQ_W-1:0] irq_en_q;

	logic silence;
	logic end_evt;
	logic [35:0] word;
	logic word_v;
	logic bwd;
	logic start;
	logic accept;
	logic finish;
	logic imm_done;
	logic [`ST_W-1:0] imm_stat;
	logic go_read;
	logic go_rew;

	assign bwd = (fn_q == tape_status_pkg::FN_RD_BWD);
	// in a backward read, silence after the last frame ends the block too
	assign end_evt = (st_q == tape_status_pkg::ST_READ) & (block_end_i | (bwd & silence));
	assign start = wr_commit & wb_sel_i[0] & (wb_adr_i == `OFS_CTRL) & (st_q == tape_status_pkg::ST_IDLE);
	assign accept = rd_commit & (wb_adr_i == `OFS_DATA_HI) & hold_v_q;
	assign finish = (st_q == tape_status_pkg::ST_DRAIN) & ~word_v & ~hold_v_q;

	// ----------------------------------------
	// function decode
	// ----------------------------------------
	always_comb begin
		imm_stat = `ST_RESET;
		imm_done = 1'b0;
		go_read = 1'b0;
		go_rew = 1'b0;
		imm_stat[`ST_DONE] = 1'b1;
		unique case (wb_dat_i[2:0])
			tape_status_pkg::FN_RD_FWD, tape_status_pkg::FN_RD_BWD, tape_status_pkg::FN_BOOT: begin
				if (wb_dat_i[2:0] == tape_status_pkg::FN_BOOT && !unit_9trk_i) begin
					imm_stat[`ST_INVAL] = 1'b1;
					imm_done = 1'b1;
				end else if (interlock_i) begin
					imm_stat[`ST_ILOCK] = 1'b1;
					imm_done = 1'b1;
				end else if (unit_busy_i) begin
					// busy with end-of-tape warning reads as a forward read would
					imm_stat[`ST_BUSY] = 1'b1;
					imm_stat[`ST_EOTW] = eot_warn_i;
					imm_done = 1'b1;
				end else if (wb_dat_i[2:0] == tape_status_pkg::FN_RD_BWD && load_point_i) begin
					imm_stat[`ST_LP] = 1'b1;
					imm_done = 1'b1;
				end else begin
					go_read = 1'b1;
				end
			end
			tape_status_pkg::FN_REWIND: begin
				if (interlock_i) begin
					imm_stat[`ST_ILOCK] = 1'b1;
					imm_done = 1'b1;
				end else if (unit_busy_i) begin
					imm_stat[`ST_BUSY] = 1'b1;
					imm_done = 1'b1;
				end else begin
					go_rew = 1'b1;
				end
			end
			default: begin
				// only the invalid and done flags, and no motion starts
				imm_stat[`ST_INVAL] = 1'b1;
				imm_done = 1'b1;
			end
		endcase
	end

	// ----------------------------------------
	// submodules
	// ----------------------------------------
	frame_packer #(
		.FW(9)
	) u_packer (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.clr_i(start),
		.frame_valid_i(frame_valid_i && st_q == tape_status_pkg::ST_READ),
		.frame_i(frame_i),
		.flush_i(end_evt),
		.word_o(word),
		.word_valid_o(word_v)
	);

	noise_gate #(
		.FRAME_CYCLES(FRAME_CYCLES)
	) u_noise (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.arm_i(st_q == tape_status_pkg::ST_READ && bwd),
		.frame_valid_i(frame_valid_i),
		.silence_o(silence)
	);

	// ----------------------------------------
	// sequencing and motion
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_q <= tape_status_pkg::ST_IDLE;
			fn_q <= tape_status_pkg::FN_NONE;
			motion_fwd_o <= 1'b0;
			motion_bwd_o <= 1'b0;
			motion_rewind_o <= 1'b0;
		end else begin
			unique case (st_q)
				tape_status_pkg::ST_IDLE: begin
					if (start) begin
						fn_q <= tape_status_pkg::func_t'(wb_dat_i[2:0]);
						if (go_read) begin
							st_q <= tape_status_pkg::ST_READ;
							motion_fwd_o <= (wb_dat_i[2:0] != tape_status_pkg::FN_RD_BWD);
							motion_bwd_o <= (wb_dat_i[2:0] == tape_status_pkg::FN_RD_BWD);
						end else if (go_rew) begin
							st_q <= tape_status_pkg::ST_REWIND;
							motion_rewind_o <= 1'b1;
						end
					end
				end
				tape_status_pkg::ST_READ: begin
					if (end_evt) begin
						// a noise frame halts the tape just like a real block
						st_q <= tape_status_pkg::ST_DRAIN;
						motion_fwd_o <= 1'b0;
						motion_bwd_o <= 1'b0;
					end
				end
				tape_status_pkg::ST_DRAIN: begin
					if (finish) begin
						st_q <= tape_status_pkg::ST_IDLE;
					end
				end
				tape_status_pkg::ST_REWIND: begin
					if (load_point_i) begin
						st_q <= tape_status_pkg::ST_IDLE;
						motion_rewind_o <= 1'b0;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// frame counting and error gathering
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || start) begin
			frames_q <= 16'h0000;
			mod_q <= 4'h0;
			first_q <= 9'h000;
			perr_q <= 1'b0;
			diag_q <= 1'b0;
			noise_q <= 1'b0;
			lp_q <= start & load_point_i;
		end else if (st_q == tape_status_pkg::ST_READ) begin
			if (frame_valid_i) begin
				frames_q <= (frames_q == 16'hFFFF) ? frames_q : frames_q + 16'h0001;
				mod_q <= (mod_q == `MOD_FRAMES) ? 4'h0 : mod_q + 4'h1;
				if (frames_q == 16'h0000) begin
					first_q <= frame_i;
				end
				perr_q <= perr_q | frame_perr_i;
			end
			diag_q <= diag_q | diag_frame_i;
			if (end_evt) begin
				perr_q <= perr_q | lrc_err_i;
				noise_q <= bwd & silence & (frames_q == 16'h0001);
			end
		end
	end

	// ----------------------------------------
	// word hand-off to the processor
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || start) begin
			hold_q <= 36'h0_0000_0000;
			hold_v_q <= 1'b0;
			made_q <= 16'h0000;
			acc_q <= 16'h0000;
			late_q <= 1'b0;
		end else begin
			if (accept) begin
				hold_v_q <= 1'b0;
				acc_q <= acc_q + 16'h0001;
			end
			// a noise frame never reaches the processor
			if (word_v && !noise_q && !(silence && bwd && frames_q == 16'h0001)) begin
				made_q <= made_q + 16'h0001;
				if (hold_v_q && !accept) begin
					// the old word was not taken in time; the new one is lost
					late_q <= 1'b1;
				end else begin
					hold_q <= word;
					hold_v_q <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// status word
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			stat_q <= `ST_RESET;
		end else if (start) begin
			stat_q <= imm_done ? imm_stat : `ST_RESET;
		end else if (finish) begin
			// a single 000010011 frame marks end-of-file
			stat_q[`ST_EOF] <= ~noise_q & (frames_q == 16'h0001) & (first_q == `EOF_PATTERN);
			// forward reads want a diagonal check frame, which eof blocks lack
			stat_q[`ST_PERR] <= perr_q | noise_q | (~bwd & ~diag_q);
			stat_q[`ST_AFC] <= (mod_q != 4'h0);
			stat_q[`ST_LATE] <= late_q;
			stat_q[`ST_LP] <= lp_q;
			stat_q[`ST_EOTW] <= eot_warn_i;
			// nonzero only when every assembled word was taken
			stat_q[`ST_FCM_MSB:`ST_FCM_LSB] <= (made_q != 16'h0000 && made_q == acc_q) ? mod_q : 4'h0;
			stat_q[`ST_DONE] <= 1'b1;
		end else if (st_q == tape_status_pkg::ST_REWIND && load_point_i) begin
			stat_q[`ST_LP] <= 1'b1;
			stat_q[`ST_DONE] <= 1'b1;
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			irq_st_q <= `IRQ_RESET;
			irq_en_q <= `IRQ_RESET;
			irq_o <= 1'b0;
		end else begin
			if (wr_commit && wb_sel_i[0] && wb_adr_i == `OFS_IRQ_EN) begin
				irq_en_q <= wb_dat_i[`IRQ_W-1:0];
			end
			// set beats a clear arriving in the same cycle
			irq_st_q <= (irq_st_q & ~((wr_commit && wb_sel_i[0] && wb_adr_i == `OFS_IRQ_CLR) ?
				wb_dat_i[`IRQ_W-1:0] : `IRQ_RESET)) |
				{word_v & hold_v_q & ~accept, word_v & ~noise_q,
				finish | (start & imm_done) | (st_q == tape_status_pkg::ST_REWIND & load_point_i)};
			irq_o <= |(irq_st_q & irq_en_q);
		end
	end

	// ----------------------------------------
	// bus answer
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
			if (req && !wb_ack_o) begin
				unique case (wb_adr_i)
					`OFS_CTRL: wb_dat_o <= {28'h000_0000, st_q != tape_status_pkg::ST_IDLE, fn_q};
					`OFS_STATUS: wb_dat_o <= {18'h0_0000, stat_q};
					`OFS_DATA_LO: wb_dat_o <= hold_q[31:0];
					`OFS_DATA_HI: wb_dat_o <= {hold_v_q, 27'h000_0000, hold_q[35:32]};
					`OFS_WORDS: wb_dat_o <= {16'h0000, acc_q};
					`OFS_IRQ_STAT: wb_dat_o <= {29'h0000_0000, irq_st_q};
					`OFS_IRQ_EN: wb_dat_o <= {29'h0000_0000, irq_en_q};
					// unmapped and write-only offsets read as zero
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule : tape_read_block_status

// ---- testbench/tape_read_block_status_asserts.sv ----
`timescale 1ns/1ps
module tape_read_block_status_asserts #(
	parameter int FRAME_CYCLES = 50
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// tape
	input wire logic frame_valid_i,
	input wire logic block_end_i,
	input wire logic motion_fwd_o,
	input wire logic motion_bwd_o,
	input wire logic motion_rewind_o,
	input wire logic irq_o
);
	// ----
	// helpers
	// ----
	// a counter keeps the long quiet bound out of the property
	logic [15:0] quiet_q;
	logic moving;
	assign moving = motion_fwd_o | motion_bwd_o;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !motion_bwd_o || frame_valid_i) begin
			quiet_q <= 16'h0000;
		end else begin
			quiet_q <= quiet_q + 16'h0001;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ans;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	sequence s_inval;
		wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_dat_i[2:0] inside {3'h0, 3'h5, 3'h6, 3'h7}
			&& !moving && !motion_rewind_o;
	endsequence
	// ----
	// checks
	// ----
	chk_ack_once: assert property (s_req |=> s_ans) else $error("ack late or too long");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	chk_reset_quiet: assert property ($rose(rst_n_i) |-> !moving && !motion_rewind_o && !irq_o && !wb_ack_o)
		else $error("outputs active after reset");
	chk_motion_one: assert property ($onehot0({motion_fwd_o, motion_bwd_o, motion_rewind_o}))
		else $error("two motion commands");
	chk_block_stop: assert property (block_end_i && moving |-> ##[1:2] !moving) else $error("tape runs on");
	chk_noise_stop: assert property (int'(quiet_q) <= 10 * FRAME_CYCLES + 3) else $error("noise not ended");
	chk_invalid_still: assert property (s_inval |=> !moving [*4]) else $error("rejected function moved");
	chk_data_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("read data changed");
endmodule : tape_read_block_status_asserts

bind tape_read_block_status tape_read_block_status_asserts #(.FRAME_CYCLES(FRAME_CYCLES)) i_chk (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.frame_valid_i(frame_valid_i),
	.block_end_i(block_end_i),
	.motion_fwd_o(motion_fwd_o),
	.motion_bwd_o(motion_bwd_o),
	.motion_rewind_o(motion_rewind_o),
	.irq_o(irq_o)
);

// ---- testbench/tape_model.sv ----
`timescale 1ns/1ps
module tape_model #(
	parameter int GAP = 10
) (
	// clock and motion
	input wire logic clk_i,
	input wire logic move_i,
	// block shape
	input wire logic [4:0] nfr_i,
	input wire logic [8:0] base_i,
	input wire logic [4:0] bad_i,
	input wire logic diag_i,
	input wire logic lrc_i,
	input wire logic quiet_i,
	// read path
	output logic frame_valid_o = 1'b0,
	output logic [8:0] frame_o = 9'h000,
	output logic frame_perr_o = 1'b0,
	output logic diag_frame_o = 1'b0,
	output logic lrc_err_o = 1'b0,
	output logic block_end_o = 1'b0
);
	int cnt_q = 0;
	int idx_q = 0;
	always @(posedge clk_i) begin
		frame_valid_o <= 1'b0;
		frame_perr_o <= 1'b0;
		diag_frame_o <= 1'b0;
		lrc_err_o <= 1'b0;
		block_end_o <= 1'b0;
		// idle lines toggle so a stale frame never looks valid
		frame_o <= ~frame_o;
		if (!move_i) begin
			cnt_q <= 0;
			idx_q <= 0;
		end else if (idx_q <= int'(nfr_i)) begin
			cnt_q <= (cnt_q == GAP - 1) ? 0 : cnt_q + 1;
			if (cnt_q == GAP - 1) begin
				idx_q <= idx_q + 1;
			end
			if (cnt_q == GAP - 1 && idx_q < int'(nfr_i)) begin
				frame_valid_o <= 1'b1;
				frame_o <= base_i + 9'(idx_q);
				frame_perr_o <= idx_q == int'(bad_i);
			end
			if (idx_q == int'(nfr_i) && cnt_q == 0) begin
				diag_frame_o <= diag_i && !quiet_i;
			end
			if (idx_q == int'(nfr_i) && cnt_q == GAP - 1) begin
				block_end_o <= !quiet_i;
				lrc_err_o <= lrc_i && !quiet_i;
			end
		end
	end
endmodule : tape_model

// ---- testbench/tape_read_block_status_tb.sv ----
`timescale 1ns/1ps
`include "tape_status_defines.svh"
module tape_read_block_status_tb;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o, rdat, st, lo, s;
	logic wb_ack_o, frame_valid_i, frame_perr_i, diag_frame_i, lrc_err_i, block_end_i;
	logic [8:0] frame_i;
	logic motion_fwd_o, motion_bwd_o, motion_rewind_o, irq_o;
	logic unit_9trk_i = 1'b1;
	logic load_point_i = 1'b0, interlock_i = 1'b0, unit_busy_i = 1'b0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [4:0] nfr = 5'h00;
	logic [4:0] bad = 5'h1F;
	logic [8:0] base = 9'h000;
	logic diag = 1'b0, lrc = 1'b0, quiet = 1'b0, ien = 1'b0;
	int mismatches = 0, check_count = 0, nw;
	always #20 clk_i = ~clk_i;
	tape_read_block_status #(.FRAME_CYCLES(3)) i_dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.frame_valid_i(frame_valid_i), .frame_i(frame_i), .frame_perr_i(frame_perr_i),
		.diag_frame_i(diag_frame_i), .lrc_err_i(lrc_err_i), .block_end_i(block_end_i),
		.load_point_i(load_point_i), .eot_warn_i(1'b0), .interlock_i(interlock_i), .unit_busy_i(unit_busy_i),
		.unit_9trk_i(unit_9trk_i), .motion_fwd_o(motion_fwd_o), .motion_bwd_o(motion_bwd_o),
		.motion_rewind_o(motion_rewind_o), .irq_o(irq_o));
	tape_model #(.GAP(10)) i_tape (
		.clk_i(clk_i), .move_i(motion_fwd_o | motion_bwd_o), .nfr_i(nfr), .base_i(base), .bad_i(bad),
		.diag_i(diag), .lrc_i(lrc), .quiet_i(quiet), .frame_valid_o(frame_valid_i), .frame_o(frame_i),
		.frame_perr_o(frame_perr_i), .diag_frame_o(diag_frame_i), .lrc_err_o(lrc_err_i),
		.block_end_o(block_end_i));
	task automatic end_sim();
		$display("mismatches %0d check_count %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 40);
		if (n >= 40) begin
			mismatches++;
			end_sim();
		end
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_sel_i <= 4'h0;
		@(posedge clk_i);
	endtask : wb
	function automatic logic [35:0] exp_w(input logic [8:0] b, input int k, input int n);
		logic [35:0] w;
		w = 36'h0_0000_0000;
		for (int i = 0; i < 4; i++) begin
			if (4 * k + i < n) begin
				w[35 - 9 * i -: 9] = b + 9'(4 * k + i);
			end
		end
		return w;
	endfunction : exp_w
	// words are taken as soon as flagged, since a late one is lost
	task automatic run(input logic [2:0] fn, input logic [4:0] n, input logic [8:0] b);
		int t;
		nw = 0;
		t = 0;
		nfr <= n;
		base <= b;
		wb(1'b1, `OFS_CTRL, {29'h0000_0000, fn});
		check({motion_fwd_o, motion_bwd_o}, (fn == tape_status_pkg::FN_RD_BWD) ? 2'b01 : 2'b10);
		do begin
			wb(1'b0, `OFS_IRQ_STAT, 32'h0000_0000);
			s = rdat;
			t++;
			if (s[`IRQ_WORD] === 1'b1) begin
				wb(1'b0, `OFS_DATA_LO, 32'h0000_0000);
				lo = rdat;
				wb(1'b0, `OFS_DATA_HI, 32'h0000_0000);
				check({rdat[31], rdat[3:0], lo}, {1'b1, exp_w(b, nw, n)});
				nw++;
				wb(1'b1, `OFS_IRQ_CLR, 32'h0000_0002);
			end
		end while (s[`IRQ_DONE] !== 1'b1 && t < 300);
		if (t >= 300) begin
			mismatches++;
			end_sim();
		end
		check(irq_o, ien);
		check({motion_fwd_o, motion_bwd_o}, 2'b00);
		wb(1'b0, `OFS_STATUS, 32'h0000_0000);
		st = rdat;
		wb(1'b0, `OFS_WORDS, 32'h0000_0000);
		check(rdat, nw);
		wb(1'b1, `OFS_IRQ_CLR, 32'h0000_0007);
		repeat (2) @(posedge clk_i);
		check(irq_o, 1'b0);
	endtask : run
	// functions answered at once: status only, tape never moves
	task automatic imm(input logic [31:0] fn, input logic [31:0] exp);
		wb(1'b1, `OFS_CTRL, fn);
		repeat (2) @(posedge clk_i);
		check({motion_fwd_o, motion_bwd_o, motion_rewind_o}, 3'b000);
		wb(1'b0, `OFS_STATUS, 32'h0000_0000);
		check(rdat, exp | (1 << `ST_DONE));
		wb(1'b1, `OFS_IRQ_CLR, 32'h0000_0007);
	endtask : imm
	initial begin
		repeat (50000) @(posedge clk_i);
		mismatches++;
		end_sim();
	end
	initial begin
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		wb(1'b0, `OFS_STATUS, 32'h0000_0000);
		check(rdat, 0);
		wb(1'b0, 8'h40, 32'h0000_0000);
		check(rdat, 0);
		wb(1'b1, `OFS_IRQ_EN, 32'h0000_0001);
		ien = 1'b1;
		diag <= 1'b1;
		run(tape_status_pkg::FN_RD_FWD, 5'h05, 9'h101);
		check(st, (1 << `ST_DONE) | (5 << `ST_FCM_LSB) | (1 << `ST_AFC));
		wb(1'b1, `OFS_IRQ_EN, 32'h0000_0000);
		ien = 1'b0;
		run(tape_status_pkg::FN_RD_FWD, 5'h0F, 9'h0A0);
		check(st, 1 << `ST_DONE);
		diag <= 1'b0;
		run(tape_status_pkg::FN_RD_FWD, 5'h01, `EOF_PATTERN);
		check(st & ~(1 << `ST_AFC), (1 << `ST_DONE) | 1 | (1 << `ST_PERR) | (1 << `ST_FCM_LSB));
		for (int i = 0; i < 2; i++) begin
			bad <= (i == 0) ? 5'h01 : 5'h1F;
			lrc <= i[0];
			run(tape_status_pkg::FN_RD_BWD, 5'h04, 9'h0C0);
			check(st, (1 << `ST_DONE) | (1 << `ST_PERR) | (1 << `ST_AFC) | (4 << `ST_FCM_LSB));
		end
		bad <= 5'h1F;
		lrc <= 1'b0;
		quiet <= 1'b1;
		run(tape_status_pkg::FN_RD_BWD, 5'h01, 9'h155);
		check(nw, 0);
		check(st[`ST_PERR], 1'b1);
		quiet <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			unit_9trk_i <= (i == 0);
			imm((i == 0) ? 32'h0000_0005 : 32'(tape_status_pkg::FN_BOOT), 1 << `ST_INVAL);
		end
		unit_9trk_i <= 1'b1;
		interlock_i <= 1'b1;
		imm(32'(tape_status_pkg::FN_BOOT), 1 << `ST_ILOCK);
		interlock_i <= 1'b0;
		unit_busy_i <= 1'b1;
		imm(32'(tape_status_pkg::FN_REWIND), 1 << `ST_BUSY);
		unit_busy_i <= 1'b0;
		wb(1'b1, `OFS_CTRL, 32'(tape_status_pkg::FN_REWIND));
		check(motion_rewind_o, 1'b1);
		load_point_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		check(motion_rewind_o, 1'b0);
		wb(1'b0, `OFS_STATUS, 32'h0000_0000);
		check(rdat, (1 << `ST_DONE) | (1 << `ST_LP));
		wb(1'b1, `OFS_IRQ_CLR, 32'h0000_0007);
		imm(32'(tape_status_pkg::FN_RD_BWD), 1 << `ST_LP);
		// the bootstrap that failed on the wrong unit is simply issued again
		diag <= 1'b1;
		run(tape_status_pkg::FN_BOOT, 5'h04, 9'h1E0);
		check(st, (1 << `ST_DONE) | (1 << `ST_LP) | (1 << `ST_AFC) | (4 << `ST_FCM_LSB));
		load_point_i <= 1'b0;
		bad <= 5'h02;
		run(tape_status_pkg::FN_RD_BWD, 5'h0D, 9'h040);
		check(st, (1 << `ST_DONE) | (1 << `ST_PERR) | (1 << `ST_AFC) | (13 << `ST_FCM_LSB));
		check(nw > 3, 1'b1);
		bad <= 5'h1F;
		// long block with parity: reposition forward, then retry backward
		for (int i = 0; i < 2; i++) begin
			run((i == 0) ? tape_status_pkg::FN_RD_FWD : tape_status_pkg::FN_RD_BWD, 5'h0D, 9'h040);
			check(st, (1 << `ST_DONE) | (1 << `ST_AFC) | (13 << `ST_FCM_LSB));
		end
		end_sim();
	end
endmodule : tape_read_block_status_tb
